//--- verilog/tdba_pkg.sv
// Package: constants and carrier types of the timer DMA burst access block
package tdba_pkg;
	localparam logic [7:0] ADDR_CTRL1 = 8'h00;
	localparam logic [7:0] ADDR_DCTRL = 8'h48;
	localparam logic [7:0] ADDR_PORT = 8'h4C;
	localparam logic [7:0] ADDR_STATUS = 8'h50;
	localparam int BASE_LSB = 0;
	localparam int BASE_MSB = 4;
	localparam int LEN_LSB = 8;
	localparam int LEN_MSB = 12;
	localparam int FIELD_W = 5;
	localparam logic [15:0] DCTRL_MASK = 16'h1F1F;
	localparam logic [15:0] DCTRL_RESET = 16'h0000;
	localparam logic [15:0] TREG_RESET = 16'h0000;
	localparam int TIMER_REG_COUNT = 18;
	localparam logic [2:0] HSIZE_BYTE = 3'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		TDBA_IDLE = 2'b00,
		TDBA_WRITE = 2'b01,
		TDBA_READ_WAIT = 2'b10,
		TDBA_READ_DONE = 2'b11
	} tdba_phase_t;

	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic [2:0] size;
	} tdba_req_t;

	typedef struct packed {
		logic strobe;
		logic write;
		logic [5:0] index;
		logic [15:0] data;
	} tdba_redirect_t;
endpackage : tdba_pkg

//--- verilog/tdba_burst_index.sv
// Burst index counter that wraps after the programmed length
`timescale 1ns/100ps
module tdba_burst_index #(
	parameter int WIDTH = 5
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic step,
	input wire logic clear,
	input wire logic [WIDTH-1:0] length,
	output logic [WIDTH-1:0] index,
	output logic last
);
	logic [WIDTH-1:0] next_index;

	assign last = (index == length);

	// Clear wins over step so a reprogrammed burst always starts at zero
	always_comb begin
		if (clear) begin
			next_index = '0;
		end else if (step && last) begin
			next_index = '0;
		end else if (step) begin
			next_index = index + WIDTH'(1);
		end else begin
			next_index = index;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			index <= '0;
		end else begin
			index <= next_index;
		end
	end
endmodule : tdba_burst_index

//--- verilog/tdba_burst_access.sv
// Timer DMA burst access: AHB-Lite slave with redirected burst register
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/100ps
module tdba_burst_access #(
	parameter int REG_COUNT = 18
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output tdba_pkg::tdba_redirect_t redirect,
	output logic [4:0] burst_index
);
	import tdba_pkg::*;

	tdba_phase_t phase;
	tdba_phase_t next_phase;
	tdba_req_t req;
	logic [15:0] dctrl;
	logic [15:0] treg [REG_COUNT];
	logic [4:0] base_field;
	logic [4:0] len_field;
	logic [4:0] idx;
	logic idx_last;
	logic trans_active;
	logic accept;
	logic port_hit;
	logic dctrl_hit;
	logic status_hit;
	logic [5:0] direct_sel;
	logic direct_hit;
	logic [7:0] target_addr;
	logic [5:0] target_sel;
	logic target_ok;
	logic byte_access;
	logic [1:0] lane;
	logic [7:0] byte_in;
	logic [15:0] port_wdata;
	logic do_write;
	logic do_read;
	logic idx_step;
	logic idx_clear;
	logic [15:0] target_rdata;
	logic [15:0] direct_rdata;
	logic [15:0] port_rdata;
	logic [31:0] next_hrdata;
	tdba_redirect_t next_redirect;

	// Address phase decode; SEQ is taken like NONSEQ, every transfer is a single here
	assign trans_active = (htrans == HTRANS_NONSEQ) || (htrans == 2'h3);
	assign accept = hsel && trans_active && hready;

	// Data phase decode on the captured request
	assign port_hit = (req.addr[7:2] == ADDR_PORT[7:2]);
	assign dctrl_hit = (req.addr[7:2] == ADDR_DCTRL[7:2]);
	assign status_hit = (req.addr[7:2] == ADDR_STATUS[7:2]);
	assign direct_sel = req.addr[7:2];
	assign direct_hit = (direct_sel < 6'(REG_COUNT));
	assign base_field = dctrl[BASE_MSB:BASE_LSB];
	assign len_field = dctrl[LEN_MSB:LEN_LSB];
	// Byte address of the target; registers sit one word apart
	assign target_addr = ADDR_CTRL1 + {1'b0, base_field, 2'b00} + {1'b0, idx, 2'b00};
	assign target_sel = target_addr[7:2];
	// Targets past the timer map (control, port itself) are not reachable
	assign target_ok = (target_sel < 6'(REG_COUNT));
	assign byte_access = (req.size == HSIZE_BYTE);
	assign lane = req.addr[1:0];
	assign byte_in = 8'(hwdata >> {lane, 3'h0});

	// Byte mode: the byte on the addressed lane, zero-extended into the low half
	assign port_wdata = byte_access ? {8'h00, byte_in} : hwdata[15:0];

	assign do_write = (phase == TDBA_WRITE) && req.write;
	assign do_read = (phase == TDBA_READ_WAIT) && !req.write;
	assign idx_step = (do_write || do_read) && port_hit;
	assign idx_clear = do_write && dctrl_hit;

	assign hreadyout = (phase != TDBA_READ_WAIT);
	assign hresp = 1'b0;
	assign burst_index = idx;

	always_comb begin
		next_phase = TDBA_IDLE;
		unique case (phase)
			TDBA_READ_WAIT: begin
				next_phase = TDBA_READ_DONE;
			end
			TDBA_IDLE, TDBA_WRITE, TDBA_READ_DONE: begin
				if (accept) begin
					next_phase = hwrite ? TDBA_WRITE : TDBA_READ_WAIT;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= TDBA_IDLE;
		end else begin
			phase <= next_phase;
		end
	end

	// Request held through its data phase, which may stretch over a wait
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req <= '0;
		end else if (accept) begin
			req <= '{addr: haddr[7:0], write: hwrite, size: hsize};
		end
	end

	tdba_burst_index #(
		.WIDTH(FIELD_W)
	) u_index (
		.hclk(hclk),
		.hresetn(hresetn),
		.step(idx_step),
		.clear(idx_clear),
		.length(len_field),
		.index(idx),
		.last(idx_last)
	);

	// Burst control register; reserved bits held at zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dctrl <= DCTRL_RESET;
		end else if (do_write && dctrl_hit) begin
			dctrl <= hwdata[15:0] & DCTRL_MASK;
		end
	end

	// Timer register file, reached directly or through the burst port
	generate
		for (genvar g = 0; g < REG_COUNT; g++) begin : g_treg
			logic hit_direct;
			logic hit_port;
			logic [15:0] direct_val;

			assign hit_direct = do_write && direct_hit && (direct_sel == 6'(g));
			assign hit_port = do_write && port_hit && target_ok && (target_sel == 6'(g));
			// Direct byte writes touch only their own half; upper lanes ignored
			always_comb begin
				direct_val = hwdata[15:0];
				if (byte_access) begin
					unique case (lane)
						2'h0: begin
							direct_val = {treg[g][15:8], byte_in};
						end
						2'h1: begin
							direct_val = {byte_in, treg[g][7:0]};
						end
						2'h2, 2'h3: begin
							direct_val = treg[g];
						end
					endcase
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					treg[g] <= TREG_RESET;
				end else if (hit_port) begin
					treg[g] <= port_wdata;
				end else if (hit_direct) begin
					treg[g] <= direct_val;
				end
			end
		end
	endgenerate

	// Read path
	assign target_rdata = target_ok ? treg[target_sel[4:0]] : 16'h0000;
	assign direct_rdata = direct_hit ? treg[direct_sel[4:0]] : 16'h0000;
	// Byte reads through the port replicate on all lanes so any lane the master picks is right
	assign port_rdata = byte_access ? {target_rdata[7:0], target_rdata[7:0]} : target_rdata;

	always_comb begin
		next_hrdata = 32'h0000_0000;
		if (port_hit) begin
			next_hrdata = byte_access ? {port_rdata, port_rdata} : {16'h0000, port_rdata};
		end else if (dctrl_hit) begin
			next_hrdata = {16'h0000, dctrl};
		end else if (status_hit) begin
			next_hrdata = {26'h0, idx_last, idx};
		end else if (direct_hit) begin
			next_hrdata = {16'h0000, direct_rdata};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (do_read) begin
			hrdata <= next_hrdata;
		end
	end

	// Redirect report to the timer core, one pulse per burst port access to a register on the timer map
	always_comb begin
		next_redirect = '0;
		if (idx_step && target_ok) begin
			next_redirect.strobe = 1'b1;
			next_redirect.write = do_write;
			next_redirect.index = target_sel;
			next_redirect.data = do_write ? port_wdata : target_rdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			redirect <= '0;
		end else begin
			redirect <= next_redirect;
		end
	end
endmodule : tdba_burst_access

//--- verification/tdba_burst_access_chk.sv
// Checker: bus timing and burst redirect properties
`timescale 1ns/100ps
module tdba_burst_access_chk #(
	parameter int REG_COUNT = 18
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire tdba_pkg::tdba_redirect_t redirect,
	input wire logic [4:0] burst_index
);
	import tdba_pkg::*;
	wire acc = hsel && htrans[1] && hready;
	wire pacc = acc && haddr[7:0] == ADDR_PORT;
	wire dacc = acc && hwrite && haddr[7:0] == ADDR_DCTRL;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait wrong");
	a_write_nowait: assert property (acc && hwrite |=> hreadyout)
		else $error("write waited");
	a_strobe_cause: assert property (redirect.strobe |-> $past(pacc, 2))
		else $error("stray strobe");
	a_index_step: assert property (pacc |-> ##2
		(burst_index == 5'($past(burst_index) + 1) || burst_index == 0))
		else $error("index step wrong");
	a_index_hold: assert property (!$stable(burst_index) |->
		$past(pacc, 2) || $past(dacc, 2))
		else $error("index moved");
	a_target_map: assert property (redirect.strobe |-> redirect.index < REG_COUNT)
		else $error("target off map");
	a_half_data: assert property (redirect.strobe && redirect.write &&
		$past(hsize, 2) != HSIZE_BYTE |-> redirect.data == $past(hwdata[15:0]))
		else $error("halfword data wrong");
	a_byte_data: assert property (redirect.strobe && redirect.write && $past(hsize, 2) ==
		HSIZE_BYTE |-> redirect.data == {8'h00, $past(hwdata[7:0])})
		else $error("byte data wrong");
endmodule : tdba_burst_access_chk

bind tdba_burst_access tdba_burst_access_chk #(.REG_COUNT(REG_COUNT)) u_chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .redirect(redirect), .burst_index(burst_index));

//--- verification/tdba_dma_model.sv
// DMA controller model: single AHB-Lite transfers
`timescale 1ns/100ps
module tdba_dma_model (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
	// Ready and read data taken as they stood at the rising edge
	task automatic wt(inout int n, output logic [31:0] q);
		logic r;
		r = 1'b0;
		q = '0;
		while (!r && n < 40) begin
			@(posedge hclk);
			r = hready;
			q = hrdata;
			n++;
		end
	endtask : wt
	task automatic xfer(input logic w, input logic [7:0] a, input logic [2:0] s,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= s;
		wt(n, q);
		htrans <= 2'h0;
		hwdata <= d;
		wt(n, q);
		if (n >= 40) begin
			test_tdba_burst_access.fails++;
			test_tdba_burst_access.final_report();
		end
		// Released data inverted, never left stale
		hwdata <= ~d;
	endtask : xfer
endmodule : tdba_dma_model

//--- verification/test_tdba_burst_access.sv
// Testbench: timer register bursts through the burst port
`timescale 1ns/100ps
module test_tdba_burst_access;
	import tdba_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] burst_index;
	tdba_redirect_t redirect;
	logic [15:0] m [TIMER_REG_COUNT];
	logic [22:0] exq [$];
	int fails = 0;
	int compares = 0;
	initial forever #2.5 hclk = ~hclk;
	tdba_burst_access u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.redirect(redirect), .burst_index(burst_index));
	tdba_dma_model u_dma (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmp
	always @(negedge hclk) begin
		if (redirect.strobe === 1'b1) begin
			cmp({31'h0, exq.size() == 0}, 32'h0);
			if (exq.size() > 0) cmp({8'h0, redirect}, {8'h0, 1'b1, exq.pop_front()});
		end
	end
	task automatic burst(input int base, input int len, input logic [2:0] s, input logic w);
		logic [15:0] item, v;
		logic [31:0] e;
		logic hit;
		int idx;
		u_dma.xfer(1'b1, ADDR_DCTRL, 3'h1, 32'(len * 256 + base), q);
		for (int i = 0; i <= len; i++) begin
			idx = base + i;
			hit = idx < TIMER_REG_COUNT;
			if (!i[0] || s != HSIZE_BYTE) item = 16'($urandom);
			v = (s != HSIZE_BYTE) ? item : {8'h00, i[0] ? item[7:0] : item[15:8]};
			if (w && hit) m[idx] = v;
			if (hit) exq.push_back({w, 6'(idx), m[idx]});
			u_dma.xfer(w, ADDR_PORT, s, {16'h0, v}, q);
			e = !hit ? 32'h0 : (s == HSIZE_BYTE) ? {4{m[idx][7:0]}} : {16'h0, m[idx]};
			if (!w) cmp(q, e);
		end
		@(posedge hclk);
		cmp({27'h0, burst_index}, 32'h0);
		cmp(32'(exq.size()), 32'h0);
		cmp({31'h0, hresp}, 32'h0);
		u_dma.xfer(1'b0, ADDR_STATUS, 3'h2, 32'h0, q);
		cmp(q, {26'h0, len == 0, 5'h0});
	endtask : burst
	task final_report;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	initial begin
		void'($urandom(48));
		foreach (m[i]) m[i] = TREG_RESET;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		u_dma.xfer(1'b0, ADDR_DCTRL, 3'h1, 32'h0, q);
		cmp(q, {16'h0, DCTRL_RESET});
		u_dma.xfer(1'b1, ADDR_DCTRL, 3'h1, 32'hFFFFFFFF, q);
		u_dma.xfer(1'b0, ADDR_DCTRL, 3'h1, 32'h0, q);
		cmp(q, {16'h0, DCTRL_MASK});
		u_dma.xfer(1'b0, 8'h60, 3'h2, 32'h0, q);
		cmp(q, 32'h0);
		burst(2, 2, 3'h1, 1'b1);
		burst(2, 2, 3'h1, 1'b0);
		burst(0, 17, 3'h2, 1'b1);
		burst(0, 17, 3'h1, 1'b0);
		burst(7, 1, HSIZE_BYTE, 1'b1);
		burst(7, 1, HSIZE_BYTE, 1'b0);
		burst(17, 1, 3'h1, 1'b1);
		burst(17, 1, 3'h1, 1'b0);
		burst(16, 0, 3'h1, 1'b1);
		u_dma.xfer(1'b0, 8'h1C, 3'h1, 32'h0, q);
		cmp(q, {16'h0, m[7]});
		final_report();
	end
endmodule : test_tdba_burst_access
